// file: kcir_top.sv
// Purpose: keypad configuration and interrupt status registers with i2c access
// Assumes: event inputs are one-cycle pulses on sys_clk; pins are asynchronous
// Notes:   link engine runs on link_clk; words cross by toggle handshake
// Contract
// R1: polarity bit picks falling or rising detection
// R2: bypass bit skips debounce on that pin
// R3: pull-up off bit disables that pin's pull-up
// R4: config bit 7 enables pointer auto-increment
// R5: without auto-increment, bytes hit one register
// R6: auto-increment ascends, wraps after 0x2e to 0
// R7: command byte for 0 or 2f is not acknowledged
// R8: config bit 6 ignores input events while locked
// R9: config bit 5 selects overwrite-oldest on overflow
// R10: config bit 4 blanks interrupt 50 us on clear
// R11: config bit 3 gates overflow onto interrupt
// R12: config bit 2 gates unlock onto interrupt
// R13: config bit 1 gates input change onto interrupt
// R14: config bit 0 gates key events onto interrupt
// R15: five status flags, each cleared by writing one
// R16: interrupt low when any enabled flag set
// R17: combo flag drives its own pin only
// R18: clear ignored while source still pending
// R19: lock flag set when lock sequence starts
// R20: zero writes keep flags; upper bits read zero
`timescale 1ns/1ns
`default_nettype none
module kcir_top (
  // clocks and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        link_clk,
  // i2c pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_n,
  // general input pins
  input  wire logic [17:0] gpi_pin,
  output var  logic [17:0] pullup_on,
  // open-drain interrupt pins
  output var  logic        int_o,
  output var  logic        int_oe_n,
  output var  logic        combo_o,
  output var  logic        combo_oe_n,
  // event sources from the rest of the device
  input  wire logic        key_event,
  input  wire logic        overrun_event,
  input  wire logic        lock_start,
  input  wire logic        combo_event,
  input  wire logic [3:0]  fifo_count,
  input  wire logic        gpi_pending,
  input  wire logic        keypad_locked,
  // controls to the rest of the device
  output var  logic        overwrite_oldest_mode,
  output var  logic [17:0] gpi_hit
);
  localparam int BLANK_SPAN = 501;

  logic [7:0]                  cfg_r;
  logic [kcir_pkg::STAT_W-1:0] stat_r;
  logic [kcir_pkg::STAT_W-1:0] stat_set;
  logic [kcir_pkg::STAT_W-1:0] stat_clr;
  logic [kcir_pkg::STAT_W-1:0] pend;
  logic [17:0]                 pol_r;
  logic [17:0]                 byp_r;
  logic [17:0]                 pull_r;
  logic                        l_wr_tgl;
  logic                        l_rd_tgl;
  logic [7:0]                  l_wr_addr;
  logic [7:0]                  l_wr_data;
  logic [7:0]                  l_rd_addr;
  logic [1:0]                  tgl_q;
  logic                        wr_seen_r;
  logic                        rd_seen_r;
  logic                        wr_fire;
  logic                        rd_fire;
  logic [7:0]                  rd_data_r;
  logic [17:0]                 pin_s;
  logic [17:0]                 samp_r;
  logic [17:0]                 deb_r;
  logic [17:0]                 prev_r;
  logic [17:0]                 edge_hit;
  logic [17:0]                 deb_upd;
  logic [kcir_pkg::DEB_W-1:0]  tick_cnt_r;
  logic                        tick;
  logic                        gpi_ev;
  logic                        stat_wr;
  logic                        blank_start;
  logic [kcir_pkg::BLANK_W-1:0] blank_cnt_r;
  logic                        int_raw;
  logic                        int_drv_r;
  logic                        combo_drv_r;

  // link engine and crossings
  kcir_i2c_tgt u_link (
    .link_clk (link_clk),
    .rst_raw  (rst),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe_n (sda_oe_n),
    .ai_raw   (cfg_r[kcir_pkg::CFG_AI]),
    .wr_tgl   (l_wr_tgl),
    .wr_addr  (l_wr_addr),
    .wr_data  (l_wr_data),
    .rd_tgl   (l_rd_tgl),
    .rd_addr  (l_rd_addr),
    .rd_data  (rd_data_r)
  );

  kcir_sync #(.W(2)) u_tgl_sync (
    .clk (sys_clk),
    .d   ({l_rd_tgl, l_wr_tgl}),
    .q   (tgl_q)
  );

  kcir_sync #(.W(18)) u_pin_sync (
    .clk (sys_clk),
    .d   (gpi_pin),
    .q   (pin_s)
  );

  // address and data are held by the link side until the next byte,
  // many sys_clk cycles after the toggle is seen
  assign wr_fire = tgl_q[0] ^ wr_seen_r;
  assign rd_fire = tgl_q[1] ^ rd_seen_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_seen_r <= 1'b0;
      rd_seen_r <= 1'b0;
    end
    else
    begin
      wr_seen_r <= tgl_q[0];
      rd_seen_r <= tgl_q[1];
    end
  end

  function automatic logic [17:0] bank_wr(input logic [17:0] old, input logic [7:0] base,
                                          input logic [7:0] a, input logic [7:0] d);
    logic [17:0] r;
    r = old;
    if (a == base)
      r[7:0] = d;
    else if (a == base + 8'h01)
      r[15:8] = d;
    else if (a == base + 8'h02)
      r[17:16] = d[1:0];
    return r;
  endfunction

  function automatic logic [7:0] bank_rd(input logic [17:0] v, input logic [1:0] sel);
    unique case (sel)
      2'd0:    return v[7:0];
      2'd1:    return v[15:8];
      2'd2:    return {6'h00, v[17:16]};
      default: return 8'h00;
    endcase
  endfunction

  // unmapped offsets belong to other slices and read zero here
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    if (a == kcir_pkg::ADDR_CFG)
      return cfg_r;
    if (a == kcir_pkg::ADDR_STAT)
      return {3'h0, stat_r}; // [R20]
    if (a >= kcir_pkg::ADDR_POL0 && a <= kcir_pkg::ADDR_POL2)
      return bank_rd(pol_r, 2'(a - kcir_pkg::ADDR_POL0));
    if (a >= kcir_pkg::ADDR_BYP0 && a <= kcir_pkg::ADDR_BYP2)
      return bank_rd(byp_r, 2'(a - kcir_pkg::ADDR_BYP0));
    if (a >= kcir_pkg::ADDR_PULL0 && a <= kcir_pkg::ADDR_PULL2)
      return bank_rd(pull_r, 2'(a - kcir_pkg::ADDR_PULL0));
    return 8'h00;
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rd_data_r <= 8'h00;
    else if (rd_fire)
      rd_data_r <= reg_read(l_rd_addr);
  end

  // configuration
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cfg_r <= kcir_pkg::CFG_RST;
    else if (wr_fire && l_wr_addr == kcir_pkg::ADDR_CFG)
      cfg_r <= l_wr_data; // [R4]
  end

  assign overwrite_oldest_mode = cfg_r[kcir_pkg::CFG_OVWR]; // [R9]

  // per-pin banks
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pol_r  <= kcir_pkg::BANK_RST;
      byp_r  <= kcir_pkg::BANK_RST;
      pull_r <= kcir_pkg::BANK_RST;
    end
    else if (wr_fire)
    begin
      pol_r  <= bank_wr(pol_r, kcir_pkg::ADDR_POL0, l_wr_addr, l_wr_data);
      byp_r  <= bank_wr(byp_r, kcir_pkg::ADDR_BYP0, l_wr_addr, l_wr_data);
      pull_r <= bank_wr(pull_r, kcir_pkg::ADDR_PULL0, l_wr_addr, l_wr_data);
    end
  end

  assign pullup_on = ~pull_r; // [R3]

  // debounce: a pin without bypass moves only when two samples a tick apart agree
  assign tick = (tick_cnt_r == kcir_pkg::DEB_W'(kcir_pkg::DEB_TICK_CYC - 1));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      tick_cnt_r <= '0;
    else if (tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 1'b1;
  end

  assign deb_upd = {18{tick}} & ~(samp_r ^ pin_s);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      samp_r <= 18'h3ffff;
      deb_r  <= 18'h3ffff;
      prev_r <= 18'h3ffff;
    end
    else
    begin
      if (tick)
        samp_r <= pin_s;
      deb_r  <= (byp_r & pin_s) | (~byp_r & ((deb_upd & pin_s) | (~deb_upd & deb_r))); // [R2]
      prev_r <= deb_r;
    end
  end

  assign edge_hit = (deb_r & ~prev_r & pol_r) | (~deb_r & prev_r & ~pol_r); // [R1]
  assign gpi_ev   = |edge_hit && !(keypad_locked && cfg_r[kcir_pkg::CFG_TRACK]); // [R8]

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      gpi_hit <= 18'h00000;
    else
      gpi_hit <= gpi_ev ? edge_hit : 18'h00000;
  end

  // status flags: a set in the same cycle as a clear wins
  assign stat_wr  = wr_fire && l_wr_addr == kcir_pkg::ADDR_STAT;
  assign pend     = {3'h0, gpi_pending, fifo_count != 4'h0};
  assign stat_set = {combo_event, overrun_event, lock_start, gpi_ev, key_event}; // [R19]
  assign stat_clr = stat_wr ? (l_wr_data[kcir_pkg::STAT_W-1:0] & ~pend) : '0; // [R18]

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      stat_r <= kcir_pkg::STAT_RST;
    else
      stat_r <= stat_set | (stat_r & ~stat_clr); // [R15] [R20]
  end

  // clearing a still-pending source can blank the pin briefly
  assign blank_start = stat_wr && cfg_r[kcir_pkg::CFG_INTCFG]
                       && |(l_wr_data[kcir_pkg::STAT_W-1:0] & pend); // [R10]

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      blank_cnt_r <= '0;
    else if (blank_start)
      blank_cnt_r <= kcir_pkg::BLANK_W'(kcir_pkg::BLANK_CYC); // [R10]
    else if (blank_cnt_r != '0)
      blank_cnt_r <= blank_cnt_r - 1'b1;
  end

  // combo flag has no enable and stays off the shared line
  assign int_raw = |(stat_r[kcir_pkg::STAT_OVR:kcir_pkg::STAT_KEY]
                     & cfg_r[kcir_pkg::CFG_OVR_IE:kcir_pkg::CFG_KEY_IE]); // [R11] [R12] [R13] [R14] [R17]

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      int_drv_r   <= 1'b0;
      combo_drv_r <= 1'b0;
    end
    else
    begin
      int_drv_r   <= int_raw && blank_cnt_r == '0; // [R16]
      combo_drv_r <= stat_r[kcir_pkg::STAT_COMBO]; // [R17]
    end
  end

  assign int_o      = 1'b0;
  assign int_oe_n   = ~int_drv_r;
  assign combo_o    = 1'b0;
  assign combo_oe_n = ~combo_drv_r;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_blank_go;
    blank_start;
  endsequence

  sequence s_quiet;
    int_oe_n [*8];
  endsequence

  a_blank_quiet: assert property (s_blank_go |-> ##2 s_quiet) // [R10]
    else $error("interrupt not released after clear");
  a_blank_load: assert property (s_blank_go |=> blank_cnt_r == kcir_pkg::BLANK_CYC) // [R10]
    else $error("blank timer load wrong");
  a_blank_end: assert property (s_blank_go |-> ##[1:BLANK_SPAN] (blank_cnt_r == '0)) // [R10]
    else $error("blank timer never expires");
  a_key_pending: assert property ((stat_r[0] && fifo_count != 4'h0) |=> stat_r[0]) // [R18]
    else $error("key flag cleared while fifo not empty");
  a_w1c_clear: assert property ((stat_wr && l_wr_data[1] && stat_r[1] && !gpi_pending && !gpi_ev)
                                |=> !stat_r[1]) // [R15]
    else $error("input flag not cleared by write one");
  a_zero_keep: assert property ((stat_wr && !l_wr_data[2] && stat_r[2]) |=> stat_r[2]) // [R20]
    else $error("lock flag lost on write zero");
  a_upper_zero: assert property ((rd_fire && l_rd_addr == kcir_pkg::ADDR_STAT) |=> rd_data_r[7:5] == 3'h0) // [R20]
    else $error("status upper bits not zero");
  a_lock_set: assert property (lock_start |=> stat_r[2]) // [R19]
    else $error("lock flag not set");
  a_int_follow: assert property ((int_raw && blank_cnt_r == '0) |=> !int_oe_n) // [R16]
    else $error("interrupt not driven");
  a_int_masked: assert property (!int_raw |=> int_oe_n) // [R11]
    else $error("interrupt driven with no enabled flag");
  a_combo_pin: assert property (stat_r[4] |=> !combo_oe_n) // [R17]
    else $error("combo pin not driven");
  a_gpi_locked: assert property ((|edge_hit && keypad_locked && cfg_r[6] && !stat_r[1]) |=> !stat_r[1]) // [R8]
    else $error("input event recorded while locked");
endmodule
`default_nettype wire

// file: kcir_pkg.sv
// Purpose: shared constants for the keypad config and interrupt register slice
// Assumes: 8-bit registers reached over an i2c target port
// Notes:   device bus address is arbitrary
package kcir_pkg;
  localparam int NPIN = 18;
  // register offsets
  localparam logic [7:0] ADDR_CFG   = 8'h01;
  localparam logic [7:0] ADDR_STAT  = 8'h02;
  localparam logic [7:0] ADDR_POL0  = 8'h26;
  localparam logic [7:0] ADDR_POL1  = 8'h27;
  localparam logic [7:0] ADDR_POL2  = 8'h28;
  localparam logic [7:0] ADDR_BYP0  = 8'h29;
  localparam logic [7:0] ADDR_BYP1  = 8'h2a;
  localparam logic [7:0] ADDR_BYP2  = 8'h2b;
  localparam logic [7:0] ADDR_PULL0 = 8'h2c;
  localparam logic [7:0] ADDR_PULL1 = 8'h2d;
  localparam logic [7:0] ADDR_PULL2 = 8'h2e;
  localparam logic [7:0] ADDR_RSVD  = 8'h2f;
  localparam logic [7:0] ADDR_WRAP  = 8'h00;
  // control_config fields
  localparam int CFG_AI      = 7;
  localparam int CFG_TRACK   = 6;
  localparam int CFG_OVWR    = 5;
  localparam int CFG_INTCFG  = 4;
  localparam int CFG_OVR_IE  = 3;
  localparam int CFG_UNL_IE  = 2;
  localparam int CFG_GPI_IE  = 1;
  localparam int CFG_KEY_IE  = 0;
  // interrupt_cause fields
  localparam int STAT_COMBO  = 4;
  localparam int STAT_OVR    = 3;
  localparam int STAT_LOCK   = 2;
  localparam int STAT_GPI    = 1;
  localparam int STAT_KEY    = 0;
  localparam int STAT_W      = 5;
  // reset values
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [4:0]  STAT_RST = 5'h00;
  localparam logic [17:0] BANK_RST = 18'h00000;
  // i2c target address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  // timing
  localparam int SYS_CLK_MHZ  = 10;
  localparam int BLANK_US     = 50;
  localparam int BLANK_CYC    = BLANK_US * SYS_CLK_MHZ;
  localparam int BLANK_W      = 9;
  localparam int DEB_TICK_US  = 10;
  localparam int DEB_TICK_CYC = DEB_TICK_US * SYS_CLK_MHZ;
  localparam int DEB_W        = 7;
endpackage

// file: kcir_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a level from another clock or a pin
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module kcir_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk,
  // data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule
`default_nettype wire

// file: kcir_i2c_tgt.sv
// Purpose: i2c target byte engine on the link clock, holds the register pointer
// Assumes: link_clk free running and well above scl rate
// Notes:   read data is requested at least half a bit time before it is shifted out
`timescale 1ns/1ns
`default_nettype none
module kcir_i2c_tgt (
  // clock and raw reset
  input  wire logic       link_clk,
  input  wire logic       rst_raw,
  // i2c pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe_n,
  // level from the register side
  input  wire logic       ai_raw,
  // write request, toggle handshake
  output var  logic       wr_tgl,
  output var  logic [7:0] wr_addr,
  output var  logic [7:0] wr_data,
  // read request, toggle handshake
  output var  logic       rd_tgl,
  output var  logic [7:0] rd_addr,
  input  wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_WDAT, S_ACK, S_RDAT, S_MACK} kcir_i2c_st_t;

  kcir_i2c_st_t st_r;
  kcir_i2c_st_t nxt_r;
  logic [3:0]   s;
  logic         scl_q;
  logic         sda_q;
  logic [3:0]   cnt_r;
  logic [7:0]   sr_r;
  logic [7:0]   tx_r;
  logic [7:0]   ptr_r;
  logic         rise;
  logic         fall;
  logic         start;
  logic         stop;

  kcir_sync #(.W(4)) u_sync (
    .clk (link_clk),
    .d   ({rst_raw, ai_raw, sda_i, scl_i}),
    .q   (s)
  );

  function automatic logic [7:0] ptr_next(input logic [7:0] p, input logic ai);
    if (!ai)
      return p;
    return (p == kcir_pkg::ADDR_PULL2) ? kcir_pkg::ADDR_WRAP : p + 8'h01;
  endfunction

  assign rise  = s[0] & ~scl_q;
  assign fall  = ~s[0] & scl_q;
  assign start = s[0] & scl_q & sda_q & ~s[1];
  assign stop  = s[0] & scl_q & ~sda_q & s[1];

  always_ff @(posedge link_clk)
  begin
    if (s[3])
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= s[0];
      sda_q <= s[1];
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (s[3])
    begin
      st_r    <= S_IDLE;
      nxt_r   <= S_IDLE;
      cnt_r   <= 4'h0;
      sr_r    <= 8'h00;
      tx_r    <= 8'h00;
      ptr_r   <= 8'h00;
      wr_tgl  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      rd_tgl  <= 1'b0;
      rd_addr <= 8'h00;
    end
    else if (start)
    begin
      st_r  <= S_ADDR;
      cnt_r <= 4'h0;
    end
    else if (stop)
      st_r <= S_IDLE;
    else
    begin
      unique case (st_r)
        S_IDLE: ;
        S_ADDR, S_CMD, S_WDAT:
          if (rise)
          begin
            sr_r  <= {sr_r[6:0], s[1]};
            cnt_r <= cnt_r + 4'h1;
          end
          else if (fall && cnt_r == 4'h8)
          begin
            cnt_r <= 4'h0;
            st_r  <= S_ACK;
            if (st_r == S_ADDR)
            begin
              if (sr_r[7:1] != kcir_pkg::DEV_ADDR)
                st_r <= S_IDLE;
              else if (sr_r[0])
              begin
                nxt_r   <= S_RDAT;
                rd_addr <= ptr_r;
                rd_tgl  <= ~rd_tgl;
              end
              else
                nxt_r <= S_CMD;
            end
            else if (st_r == S_CMD)
            begin
              // pointer 0 or reserved and higher pointers are left unanswered
              if (sr_r == kcir_pkg::ADDR_WRAP || sr_r >= kcir_pkg::ADDR_RSVD) // [R7]
                st_r <= S_IDLE;
              ptr_r <= sr_r;
              nxt_r <= S_WDAT;
            end
            else
            begin
              wr_addr <= ptr_r; // [R5]
              wr_data <= sr_r;
              wr_tgl  <= ~wr_tgl;
              ptr_r   <= ptr_next(ptr_r, s[2]); // [R4] [R6]
              nxt_r   <= S_WDAT;
            end
          end
        S_ACK:
          if (fall)
          begin
            st_r <= nxt_r;
            tx_r <= rd_data;
          end
        S_RDAT:
          if (fall)
          begin
            tx_r  <= {tx_r[6:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h7)
            begin
              st_r  <= S_MACK;
              cnt_r <= 4'h0;
            end
          end
        S_MACK:
          if (rise)
          begin
            if (s[1])
              st_r <= S_IDLE;
            else
            begin
              ptr_r   <= ptr_next(ptr_r, s[2]); // [R4] [R6]
              rd_addr <= ptr_next(ptr_r, s[2]);
              rd_tgl  <= ~rd_tgl;
            end
          end
          else if (fall)
          begin
            st_r <= S_RDAT;
            tx_r <= rd_data;
          end
      endcase
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = ~((st_r == S_ACK) | ((st_r == S_RDAT) & ~tx_r[7]));
endmodule
`default_nettype wire

// file: kcir_host.sv
// Purpose: i2c host model for the register slice
// Assumes: open-drain lines with pull-ups, resolved in the bench
// Notes:   quarter bit of 10 sys_clk keeps scl low for 2 us
`timescale 1ns/1ns
`default_nettype none
module kcir_host (
  // clock
  input  wire logic sys_clk,
  // i2c lines
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull_n
);
  localparam int QTR = 10;
  initial
  begin
    scl = 1'b1;
    sda_pull_n = 1'b1;
  end
  task automatic wq();
    repeat (QTR) @(posedge sys_clk);
  endtask
  // data only moves while scl is low, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    sda_pull_n <= b;
    wq();
    scl <= 1'b1;
    wq();
    s = sda;
    wq();
    scl <= 1'b0;
    wq();
  endtask
  task automatic start();
    sda_pull_n <= 1'b1;
    wq();
    scl <= 1'b1;
    wq();
    sda_pull_n <= 1'b0;
    wq();
    scl <= 1'b0;
    wq();
  endtask
  task automatic stop();
    sda_pull_n <= 1'b0;
    wq();
    scl <= 1'b1;
    wq();
    sda_pull_n <= 1'b1;
    wq();
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] q [$], output logic ok);
    logic a;
    start();
    tx({kcir_pkg::DEV_ADDR, 1'b0}, ok);
    tx(cmd, a);
    ok = ok & a;
    foreach (q[i])
    begin
      tx(q[i], a);
      ok = ok & a;
    end
    stop();
  endtask
  // last byte gets a nack so the target lets go of sda
  task automatic rd(input logic [7:0] cmd, input int n, output logic [7:0] r [$], output logic ok);
    logic a;
    logic s;
    logic [7:0] b;
    r = {};
    start();
    tx({kcir_pkg::DEV_ADDR, 1'b0}, ok);
    tx(cmd, a);
    ok = ok & a;
    start();
    tx({kcir_pkg::DEV_ADDR, 1'b1}, a);
    ok = ok & a;
    for (int k = 0; k < n; k++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        bit_io(1'b1, s);
        b[i] = s;
      end
      bit_io(k == n - 1, s);
      r.push_back(b);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// file: keypad_config_interrupt_regs_test.sv
// Purpose: self-checking bench for the config and status slice
// Assumes: host model on the i2c lines, bench drives event sources
// Notes:   register model mirrors pointer and clear rules
`timescale 1ns/1ns
`default_nettype none
module keypad_config_interrupt_regs_test;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst = 1'b1;
  logic [17:0] gpi_pin = '1;
  logic [4:0]  ev = '0;
  logic [3:0]  fifo_count = '0;
  logic        keypad_locked = 1'b0;
  logic        gpi_pend = 1'b0;
  logic [7:0]  st = '0;
  logic [7:0]  m [48] = '{default: 8'h00};
  logic [7:0]  bad [3] = '{8'h00, 8'h2f, 8'h30};
  int          src [3] = '{0, 2, 3};
  logic [31:0] seed = 32'hf07e;
  logic [7:0]  d [$];
  logic        ok;
  int          mismatches = 0;
  int          tests_run = 0;
  int          n;
  wire logic   scl, host_pull_n, sda, sda_o, sda_oe_n, int_oe_n, combo_oe_n, mode;
  wire logic [17:0] pullup_on, gpi_hit;
  assign sda = host_pull_n & (sda_oe_n | sda_o);
  always #50 sys_clk = ~sys_clk;
  initial
  begin
    #17;
    forever #40 link_clk = ~link_clk;
  end
  kcir_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull_n(host_pull_n));
  kcir_top dut (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .gpi_pin(gpi_pin), .pullup_on(pullup_on), .int_o(),
    .int_oe_n(int_oe_n), .combo_o(), .combo_oe_n(combo_oe_n), .key_event(ev[0]),
    .overrun_event(ev[3]), .lock_start(ev[2]), .combo_event(ev[4]), .fifo_count(fifo_count),
    .gpi_pending(gpi_pend), .keypad_locked(keypad_locked), .overwrite_oldest_mode(mode), .gpi_hit(gpi_hit));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] exp_of(input int p);
    if (p == 2) return st;
    return (p == 1 || (p > 'h25 && p < 'h2f)) ? m[p] : 8'h00;
  endfunction
  function automatic logic cond(input int s);
    return s < 2 ? int_oe_n === s[0] : gpi_hit[s-2] === 1'b1;
  endfunction
  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic wt(input int s, input int lim, input bit must);
    for (n = 0; n < lim && !cond(s); n++) @(negedge sys_clk);
    if (must && n == lim)
    begin
      mismatches++;
      $display("[ERR] %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  // upper bits of the third bank of each kind do not exist
  task automatic bw(input int p, input logic [7:0] q [$]);
    host.wr(p[7:0], q, ok);
    chk(ok, 1'b1);
    foreach (q[i])
    begin
      if (p == 2) st &= ~(q[i] & 8'h1f & ~{6'h00, gpi_pend, fifo_count != 4'h0});
      else if (p == 1 || (p > 'h25 && p < 'h2f)) m[p] = q[i] & ((p > 2 && p % 3 == 1) ? 8'h03 : 8'hff);
      if (m[1][7]) p = (p == 'h2e) ? 0 : p + 1;
    end
  endtask
  task automatic br(input int p, input int cnt);
    logic [7:0] r [$];
    host.rd(p[7:0], cnt, r, ok);
    chk(ok, 1'b1);
    foreach (r[i])
    begin
      chk(r[i], exp_of(p));
      if (m[1][7]) p = (p == 'h2e) ? 0 : p + 1;
    end
  endtask
  task automatic pulse(input int b);
    @(posedge sys_clk);
    ev[b] <= 1'b1;
    @(posedge sys_clk);
    ev[b] <= 1'b0;
    st[b] = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic ichk();
    chk(int_oe_n, (st[3:0] & m[1][3:0]) == 4'h0);
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (12) @(negedge sys_clk);
    chk(pullup_on, 18'h3ffff);
    chk({int_oe_n, combo_oe_n, mode, gpi_hit}, 21'h180000);
    bw(1, {8'h80});
    br('h26, 9);
    for (int i = 0; i < 11; i++) d.push_back(rnd());
    d[10] = d[10] | 8'h80;
    bw('h26, d);
    br('h26, 9);
    br(1, 1);
    chk(pullup_on, 18'(~{m['h2e][1:0], m['h2d], m['h2c]}));
    chk(mode, m[1][5]);
    bw(1, {8'h00});
    bw('h27, {rnd(), rnd(), rnd()});
    br('h27, 2);
    br('h28, 1);
    foreach (bad[i])
    begin
      host.wr(bad[i], d, ok);
      chk(ok, 1'b0);
    end
    br(1, 1);
    foreach (src[i])
      for (int en = 0; en < 2; en++)
      begin
        bw(1, {8'(en << src[i])});
        pulse(src[i]);
        ichk();
        br(2, 1);
        bw(2, {8'h01 << src[i]});
      end
    bw(1, {8'h0f});
    pulse(4);
    chk({combo_oe_n, int_oe_n}, 2'b01);
    bw(2, {8'h10});
    chk(combo_oe_n, 1'b1);
    @(posedge sys_clk);
    fifo_count <= 4'h3;
    pulse(0);
    bw(2, {8'he0});
    bw(2, {8'h01});
    br(2, 1);
    ichk();
    bw(1, {8'h11});
    bw(2, {8'h01});
    chk(int_oe_n, 1'b1);
    wt(0, 600, 1);
    chk(n > 380 && n < 480, 1'b1);
    @(posedge sys_clk);
    fifo_count <= 4'h0;
    bw(2, {8'h01});
    bw(1, {8'h02});
    bw('h29, {8'h01});
    bw('h26, {8'h00});
    bw('h27, {8'h01});
    @(posedge sys_clk);
    gpi_pin[0] <= 1'b0;
    wt(2, 30, 1);
    @(posedge sys_clk);
    gpi_pin[1] <= 1'b0;
    wt(3, 400, 1);
    chk(n > 90, 1'b1);
    st[1] = 1'b1;
    ichk();
    @(posedge sys_clk);
    gpi_pin[8] <= 1'b0;
    wt(10, 300, 0);
    chk(n, 300);
    @(posedge sys_clk);
    gpi_pin[8] <= 1'b1;
    wt(10, 400, 1);
    @(posedge sys_clk);
    gpi_pend <= 1'b1;
    bw(2, {8'h02});
    br(2, 1);
    gpi_pend <= 1'b0;
    bw(2, {8'h02});
    bw(1, {8'h42});
    @(posedge sys_clk);
    gpi_pin[0] <= 1'b1;
    repeat (30) @(posedge sys_clk);
    keypad_locked <= 1'b1;
    gpi_pin[0] <= 1'b0;
    wt(2, 50, 0);
    chk(n, 50);
    br(2, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
